// ==== scfd_params.svh ====
// Function
// - bus address is word 0x02 bit 23 (high) and bit 22 (low).
// - default address: 0 single die or first die, 1 second die.
// - calibration filter code 0..3: 0.08,0.3,1.25,4 Hz; codes 4-7 16 Hz.
// - calibration filter code never changes coil self test response time.
// - lower calibration bandwidth lengthens compensation settling; flagged to software.
// - signal filter code 0..3: 40,160,680,3000 Hz; codes 4-7 7400 Hz.
// - upper clamp bits 11:0 inverted: 0x0 maximum, 0xFFF minimum.
// - lower clamp bits 23:12 plain: 0x0 minimum, 0xFFF maximum.
`ifndef SCFD_PARAMS_SVH
`define SCFD_PARAMS_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define SCFD_IDX_BUS_ADDR   8'h02
`define SCFD_IDX_FILTER     8'h03
`define SCFD_IDX_CLAMP      8'h08
`define SCFD_IDX_STATUS     8'h10
`define SCFD_IDX_SAMPLE     8'h11
// ************************************************************
// field positions
// ************************************************************
`define SCFD_ADDR_LO_BIT    22
`define SCFD_ADDR_HI_BIT    23
`define SCFD_CAL_MSB        21
`define SCFD_CAL_LSB        19
`define SCFD_SIG_MSB        18
`define SCFD_SIG_LSB        16
`define SCFD_CLPH_MSB       11
`define SCFD_CLPH_LSB       0
`define SCFD_CLPL_MSB       23
`define SCFD_CLPL_LSB       12
// ************************************************************
// reset values and cutoffs (centihertz)
// ************************************************************
`define SCFD_RST_WORD       32'h0000_0000
`define SCFD_ADDR_DIE1      2'h0
`define SCFD_ADDR_DIE2      2'h1
`define SCFD_ADDR_DIE2_WORD 32'h0040_0000
`define SCFD_CAL_HZ0        20'h00008
`define SCFD_CAL_HZ1        20'h0001E
`define SCFD_CAL_HZ2        20'h0007D
`define SCFD_CAL_HZ3        20'h00190
`define SCFD_CAL_HZ4        20'h00640
`define SCFD_SIG_HZ0        20'h00FA0
`define SCFD_SIG_HZ1        20'h03E80
`define SCFD_SIG_HZ2        20'h109A0
`define SCFD_SIG_HZ3        20'h493E0
`define SCFD_SIG_HZ4        20'hB4AA0
`define SCFD_SLOW_CAL_CODE  3'h1
`define SCFD_COIL_TEST_CYC  16'h0100
`endif

// ==== scfd_pkg.sv ====
package scfd_pkg;
  typedef logic [11:0] scfd_level_t;
  typedef logic [19:0] scfd_centihz_t;
  typedef enum logic [1:0] {
    SCFD_ST_IDLE = 2'b00,
    SCFD_ST_TEST = 2'b01,
    SCFD_ST_DONE = 2'b10
  } scfd_test_state_e;
endpackage

// ==== scfd_cfg_if.sv ====
`timescale 1ns/1ps
interface scfd_cfg_if;
  import scfd_pkg::*;
  scfd_level_t upper_lvl;
  scfd_level_t lower_lvl;
  logic [11:0] raw_value;
  logic [11:0] limited_value;
  modport top   (output upper_lvl, output lower_lvl, output raw_value, input limited_value);
  modport clamp (input upper_lvl, input lower_lvl, input raw_value, output limited_value);
endinterface

// ==== scfd_clamp.sv ====
`timescale 1ns/1ps
module scfd_clamp
  import scfd_pkg::*;
(
  scfd_cfg_if.clamp cfg
);
  always_comb begin
    if (cfg.raw_value > cfg.upper_lvl) begin
      cfg.limited_value = cfg.upper_lvl;
    end else if (cfg.raw_value < cfg.lower_lvl) begin
      cfg.limited_value = cfg.lower_lvl;
    end else begin
      cfg.limited_value = cfg.raw_value;
    end
  end
endmodule

// ==== sensor_config_field_decode.sv ====
`timescale 1ns/1ps
`include "scfd_params.svh"
module sensor_config_field_decode
  import scfd_pkg::*;
#(
  parameter bit SECOND_DIE = 1'b0
)(
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          CE,
  input  wire logic [7:0]    ADDR,
  input  wire logic [31:0]   WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [31:0]   RDATA,
  input  wire logic [11:0]   SAMPLE_IN,
  input  wire logic          SAMPLE_VALID,
  input  wire logic          COIL_SELF_TEST_START,
  output logic      [1:0]    BUS_ADDRESS,
  output logic      [2:0]    CALIB_FILTER_CUTOFF_SEL,
  output logic      [2:0]    SIGNAL_FILTER_CUTOFF_SEL,
  output logic      [19:0]   CALIB_CUTOFF_CHZ,
  output logic      [19:0]   SIGNAL_CUTOFF_CHZ,
  output logic      [11:0]   UPPER_LIMIT_OUTPUT,
  output logic      [11:0]   LOWER_LIMIT_OUTPUT,
  output logic      [11:0]   LIMITED_OUT,
  output logic               COIL_SELF_TEST_BUSY,
  output logic               SLOW_SETTLE
);
  // ************************************************************
  // registers
  // ************************************************************
  logic [31:0]      bus_address_word_reg;
  logic [31:0]      filter_select_word_reg;
  logic [31:0]      output_clamp_word_reg;
  logic [11:0]      sample_reg;
  logic [15:0]      test_cnt_reg;
  scfd_test_state_e test_state_reg;
  scfd_test_state_e test_state_next;
  scfd_cfg_if       cfg ();

  // ************************************************************
  // per-die reset values
  // ************************************************************
  // per-die default
  localparam logic [31:0] addr_word_rst = SECOND_DIE ? `SCFD_ADDR_DIE2_WORD : `SCFD_RST_WORD;
  localparam logic [1:0]  addr_rst      = SECOND_DIE ? `SCFD_ADDR_DIE2 : `SCFD_ADDR_DIE1;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_address_word_reg <= addr_word_rst;
    end else if (CE && WR && ADDR == `SCFD_IDX_BUS_ADDR) begin
      bus_address_word_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      filter_select_word_reg <= `SCFD_RST_WORD;
    end else if (CE && WR && ADDR == `SCFD_IDX_FILTER) begin
      filter_select_word_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      output_clamp_word_reg <= `SCFD_RST_WORD;
    end else if (CE && WR && ADDR == `SCFD_IDX_CLAMP) begin
      output_clamp_word_reg <= WDATA;
    end
  end

  // ************************************************************
  // field decode
  // ************************************************************
  // address bits
  // bit 23 high, bit 22 low, no per-die offset
  logic [1:0] stored_addr;
  assign stored_addr = {bus_address_word_reg[`SCFD_ADDR_HI_BIT],
                        bus_address_word_reg[`SCFD_ADDR_LO_BIT]};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      BUS_ADDRESS <= addr_rst;
    end else if (CE) begin
      BUS_ADDRESS <= stored_addr;
    end
  end

  logic [2:0] cal_code;
  logic [2:0] sig_code;
  assign cal_code = filter_select_word_reg[`SCFD_CAL_MSB:`SCFD_CAL_LSB];
  assign sig_code = filter_select_word_reg[`SCFD_SIG_MSB:`SCFD_SIG_LSB];

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CALIB_FILTER_CUTOFF_SEL  <= 3'h0;
      SIGNAL_FILTER_CUTOFF_SEL <= 3'h0;
      CALIB_CUTOFF_CHZ         <= `SCFD_CAL_HZ0;
      SIGNAL_CUTOFF_CHZ        <= `SCFD_SIG_HZ0;
      SLOW_SETTLE              <= 1'b1;
    end else if (CE) begin
      CALIB_FILTER_CUTOFF_SEL  <= cal_code;
      SIGNAL_FILTER_CUTOFF_SEL <= sig_code;
      case (cal_code)
        3'h0:    CALIB_CUTOFF_CHZ <= `SCFD_CAL_HZ0;
        3'h1:    CALIB_CUTOFF_CHZ <= `SCFD_CAL_HZ1;
        3'h2:    CALIB_CUTOFF_CHZ <= `SCFD_CAL_HZ2;
        3'h3:    CALIB_CUTOFF_CHZ <= `SCFD_CAL_HZ3;
        default: CALIB_CUTOFF_CHZ <= `SCFD_CAL_HZ4;
      endcase
      case (sig_code)
        3'h0:    SIGNAL_CUTOFF_CHZ <= `SCFD_SIG_HZ0;
        3'h1:    SIGNAL_CUTOFF_CHZ <= `SCFD_SIG_HZ1;
        3'h2:    SIGNAL_CUTOFF_CHZ <= `SCFD_SIG_HZ2;
        3'h3:    SIGNAL_CUTOFF_CHZ <= `SCFD_SIG_HZ3;
        default: SIGNAL_CUTOFF_CHZ <= `SCFD_SIG_HZ4;
      endcase
      SLOW_SETTLE <= (cal_code <= `SCFD_SLOW_CAL_CODE);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      UPPER_LIMIT_OUTPUT <= 12'hFFF;
      LOWER_LIMIT_OUTPUT <= 12'h000;
    end else if (CE) begin
      UPPER_LIMIT_OUTPUT <= ~output_clamp_word_reg[`SCFD_CLPH_MSB:`SCFD_CLPH_LSB];
      LOWER_LIMIT_OUTPUT <= output_clamp_word_reg[`SCFD_CLPL_MSB:`SCFD_CLPL_LSB];
    end
  end

  // ************************************************************
  // output limiting
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sample_reg <= 12'h000;
    end else if (CE && SAMPLE_VALID) begin
      sample_reg <= SAMPLE_IN;
    end
  end

  assign cfg.upper_lvl = UPPER_LIMIT_OUTPUT;
  assign cfg.lower_lvl = LOWER_LIMIT_OUTPUT;
  assign cfg.raw_value = sample_reg;

  // crossed limits: samples above the upper limit take it, all others take the lower limit
  scfd_clamp u_clamp (
    .cfg (cfg)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      LIMITED_OUT <= 12'h000;
    end else if (CE) begin
      LIMITED_OUT <= cfg.limited_value;
    end
  end

  // ************************************************************
  // coil self test timer
  // ************************************************************
  // fixed test length
  always_comb begin
    test_state_next = test_state_reg;
    case (test_state_reg)
      SCFD_ST_IDLE: begin
        if (COIL_SELF_TEST_START) begin
          test_state_next = SCFD_ST_TEST;
        end
      end
      SCFD_ST_TEST: begin
        if (test_cnt_reg == `SCFD_COIL_TEST_CYC - 16'h0001) begin
          test_state_next = SCFD_ST_DONE;
        end
      end
      SCFD_ST_DONE: begin
        test_state_next = SCFD_ST_IDLE;
      end
      default: begin
        test_state_next = SCFD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      test_state_reg <= SCFD_ST_IDLE;
      test_cnt_reg   <= 16'h0000;
    end else if (CE) begin
      test_state_reg <= test_state_next;
      test_cnt_reg   <= (test_state_reg == SCFD_ST_TEST) ? test_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  assign COIL_SELF_TEST_BUSY = (test_state_reg == SCFD_ST_TEST);

  // ************************************************************
  // register read
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 32'h0000_0000;
    end else if (CE) begin
      RDATA <= 32'h0000_0000;
      if (RD) begin
        case (ADDR)
          `SCFD_IDX_BUS_ADDR: RDATA <= bus_address_word_reg;
          `SCFD_IDX_FILTER:   RDATA <= filter_select_word_reg;
          `SCFD_IDX_CLAMP:    RDATA <= output_clamp_word_reg;
          `SCFD_IDX_STATUS:   RDATA <= {27'h0, SLOW_SETTLE, COIL_SELF_TEST_BUSY, 1'b0, BUS_ADDRESS};
          `SCFD_IDX_SAMPLE:   RDATA <= {20'h0, LIMITED_OUT};
          default:            RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== scfd_properties.sv ====
`timescale 1ns/1ps
// ************
// decode checks
// ************
module scfd_properties #(
  parameter bit SECOND_DIE = 1'b0
)(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CE,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic [11:0] SAMPLE_IN,
  input wire logic        SAMPLE_VALID,
  input wire logic [1:0]  BUS_ADDRESS,
  input wire logic [2:0]  CALIB_FILTER_CUTOFF_SEL,
  input wire logic [2:0]  SIGNAL_FILTER_CUTOFF_SEL,
  input wire logic [19:0] CALIB_CUTOFF_CHZ,
  input wire logic [19:0] SIGNAL_CUTOFF_CHZ,
  input wire logic [11:0] UPPER_LIMIT_OUTPUT,
  input wire logic [11:0] LOWER_LIMIT_OUTPUT,
  input wire logic [11:0] LIMITED_OUT,
  input wire logic        COIL_SELF_TEST_BUSY,
  input wire logic        SLOW_SETTLE
);
  localparam logic [19:0] CAL [5] = '{20'h00008, 20'h0001E, 20'h0007D, 20'h00190, 20'h00640};
  localparam logic [19:0] SIG [5] = '{20'h00FA0, 20'h03E80, 20'h109A0, 20'h493E0, 20'hB4AA0};
  logic [15:0] run_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  function automatic logic [11:0] lim(input logic [11:0] s, input logic [11:0] u,
                                      input logic [11:0] l);
    return (s > u) ? u : ((s < l) ? l : s);
  endfunction
  // length of the current busy run
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_reg <= 16'h0000;
    end else begin
      if (!COIL_SELF_TEST_BUSY) begin
        run_reg <= 16'h0000;
      end else if (CE) begin
        run_reg <= run_reg + 16'h0001;
      end
    end
  end
  sequence s_wr(logic [7:0] a);
    (CE && WR && ADDR == a) ##1 CE;
  endsequence
  chk_bus_addr: assert property (
    s_wr(8'h02) |-> ##1 BUS_ADDRESS == $past(WDATA[23:22], 2))
    else $error("bus address");
  chk_addr_default: assert property (
    $rose(RST_B) |-> BUS_ADDRESS == {1'b0, SECOND_DIE})
    else $error("default address");
  chk_calib_cut: assert property (
    s_wr(8'h03) |-> ##1 CALIB_FILTER_CUTOFF_SEL == $past(WDATA[21:19], 2) &&
      CALIB_CUTOFF_CHZ == CAL[(CALIB_FILTER_CUTOFF_SEL > 3'h3) ? 3'h4 : CALIB_FILTER_CUTOFF_SEL])
    else $error("calib cutoff");
  chk_signal_cut: assert property (
    s_wr(8'h03) |-> ##1 SIGNAL_FILTER_CUTOFF_SEL == $past(WDATA[18:16], 2) &&
      SIGNAL_CUTOFF_CHZ == SIG[(SIGNAL_FILTER_CUTOFF_SEL > 3'h3) ? 3'h4 : SIGNAL_FILTER_CUTOFF_SEL])
    else $error("signal cutoff");
  chk_slow_flag: assert property (
    s_wr(8'h03) |-> ##1 SLOW_SETTLE == ($past(WDATA[21:19], 2) <= 3'h1))
    else $error("slow settle");
  chk_upper_inv: assert property (
    s_wr(8'h08) |-> ##1 UPPER_LIMIT_OUTPUT == ~$past(WDATA[11:0], 2))
    else $error("upper clamp");
  chk_lower_plain: assert property (
    s_wr(8'h08) |-> ##1 LOWER_LIMIT_OUTPUT == $past(WDATA[23:12], 2))
    else $error("lower clamp");
  chk_limit_range: assert property (
    (SAMPLE_VALID && CE) ##1 CE |-> ##1 LIMITED_OUT == lim($past(SAMPLE_IN, 2),
      $past(UPPER_LIMIT_OUTPUT), $past(LOWER_LIMIT_OUTPUT)))
    else $error("limited output");
  chk_test_len: assert property (
    $fell(COIL_SELF_TEST_BUSY) |-> run_reg == 16'h0100)
    else $error("self test length");
endmodule

// ==== scfd_programmer.sv ====
`timescale 1ns/1ps
// ************
// programmer
// ************
module scfd_programmer (
  input  wire logic        CLK,
  input  wire logic [31:0] RDATA,
  output logic      [7:0]  ADDR,
  output logic      [31:0] WDATA,
  output logic             WR,
  output logic             RD
);
  initial begin
    ADDR = 8'h00;
    WDATA = 32'h00000000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    ADDR <= ~a;
    @(negedge CLK);
    d = RDATA;
  endtask
endmodule

// ==== sensor_config_field_decode_tb.sv ====
`timescale 1ns/1ps
// ************
// bench
// ************
module sensor_config_field_decode_tb;
  logic        CLK, RST_B, CE, WR, RD, SAMPLE_VALID, COIL_SELF_TEST_START;
  logic        COIL_SELF_TEST_BUSY, SLOW_SETTLE;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, rd_val;
  logic [11:0] SAMPLE_IN, UPPER_LIMIT_OUTPUT, LOWER_LIMIT_OUTPUT, LIMITED_OUT;
  logic [2:0]  CALIB_FILTER_CUTOFF_SEL, SIGNAL_FILTER_CUTOFF_SEL;
  logic [19:0] CALIB_CUTOFF_CHZ, SIGNAL_CUTOFF_CHZ;
  logic [19:0] cal_chz [8] = '{20'h00008, 20'h0001E, 20'h0007D, 20'h00190,
                               20'h00640, 20'h00640, 20'h00640, 20'h00640};
  logic [19:0] sig_chz [8] = '{20'h00FA0, 20'h03E80, 20'h109A0, 20'h493E0,
                               20'hB4AA0, 20'hB4AA0, 20'hB4AA0, 20'hB4AA0};
  logic [1:0]  BUS_ADDRESS;
  logic [11:0] smp [3] = '{12'h005, 12'h7AB, 12'hFFF};
  logic [11:0] exp_lim [3] = '{12'h010, 12'h7AB, 12'hF00};
  int          errors, checks, n;
  sensor_config_field_decode i_dut (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_VALID(SAMPLE_VALID),
    .COIL_SELF_TEST_START(COIL_SELF_TEST_START), .BUS_ADDRESS(BUS_ADDRESS),
    .CALIB_FILTER_CUTOFF_SEL(CALIB_FILTER_CUTOFF_SEL), .CALIB_CUTOFF_CHZ(CALIB_CUTOFF_CHZ),
    .SIGNAL_FILTER_CUTOFF_SEL(SIGNAL_FILTER_CUTOFF_SEL), .SIGNAL_CUTOFF_CHZ(SIGNAL_CUTOFF_CHZ),
    .UPPER_LIMIT_OUTPUT(UPPER_LIMIT_OUTPUT), .LOWER_LIMIT_OUTPUT(LOWER_LIMIT_OUTPUT),
    .LIMITED_OUT(LIMITED_OUT), .COIL_SELF_TEST_BUSY(COIL_SELF_TEST_BUSY),
    .SLOW_SETTLE(SLOW_SETTLE));
  scfd_programmer i_prog (
    .CLK(CLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (2) @(negedge CLK);
  endtask
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    RST_B = 1'b0;
    CE = 1'b1;
    SAMPLE_IN = 12'h000;
    SAMPLE_VALID = 1'b0;
    COIL_SELF_TEST_START = 1'b0;
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    @(negedge CLK);
    cmp("upper reset", 32'h00000FFF, UPPER_LIMIT_OUTPUT);
    cmp("address reset", 32'h00000000, BUS_ADDRESS);
    for (int v = 0; v < 4; v++) begin
      i_prog.wr(8'h02, {8'h00, v[1:0], 22'h2AAAAA});
      settle;
      cmp("bus address", v, BUS_ADDRESS);
    end
    // writes with clock enable low or to a free index are dropped
    @(posedge CLK);
    CE <= 1'b0;
    i_prog.wr(8'h02, 32'h00000000);
    CE <= 1'b1;
    i_prog.wr(8'h05, 32'hFFFFFFFF);
    settle;
    cmp("address held", 32'h00000003, BUS_ADDRESS);
    i_prog.rd(8'h02, rd_val);
    cmp("address word", 32'h00EAAAAA, rd_val);
    i_prog.rd(8'h05, rd_val);
    cmp("unmapped read", 32'h00000000, rd_val);
    for (int c = 0; c < 8; c++) begin
      i_prog.wr(8'h03, {10'h000, c[2:0], ~c[2:0], 16'h1234});
      settle;
      cmp("calib sel", c, CALIB_FILTER_CUTOFF_SEL);
      cmp("signal sel", 7 - c, SIGNAL_FILTER_CUTOFF_SEL);
      cmp("calib cutoff", cal_chz[c], CALIB_CUTOFF_CHZ);
      cmp("signal cutoff", sig_chz[7 - c], SIGNAL_CUTOFF_CHZ);
      cmp("slow settle", c < 2, SLOW_SETTLE);
      @(posedge CLK);
      COIL_SELF_TEST_START <= 1'b1;
      @(posedge CLK);
      COIL_SELF_TEST_START <= 1'b0;
      n = 0;
      @(negedge CLK);
      while (COIL_SELF_TEST_BUSY === 1'b1 && n < 400) begin
        n++;
        @(negedge CLK);
      end
      cmp("test cycles", 256, n);
      if (n >= 400) test_done;
    end
    i_prog.wr(8'h08, 32'h000100FF);
    settle;
    cmp("upper level", 32'h00000F00, UPPER_LIMIT_OUTPUT);
    cmp("lower level", 32'h00000010, LOWER_LIMIT_OUTPUT);
    foreach (smp[i]) begin
      @(posedge CLK);
      SAMPLE_IN <= smp[i];
      SAMPLE_VALID <= 1'b1;
      @(posedge CLK);
      SAMPLE_VALID <= 1'b0;
      SAMPLE_IN <= ~smp[i];
      settle;
      cmp("limited", exp_lim[i], LIMITED_OUT);
    end
    i_prog.rd(8'h03, rd_val);
    cmp("filter word", 32'h00381234, rd_val);
    i_prog.rd(8'h08, rd_val);
    cmp("clamp word", 32'h000100FF, rd_val);
    i_prog.rd(8'h11, rd_val);
    cmp("sample read", 32'h00000F00, rd_val);
    i_prog.rd(8'h10, rd_val);
    cmp("status read", 32'h00000003, rd_val);
    test_done;
  end
endmodule
bind sensor_config_field_decode scfd_properties #(.SECOND_DIE(SECOND_DIE)) u_chk (
  .CLK(CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .SAMPLE_IN(SAMPLE_IN), .SAMPLE_VALID(SAMPLE_VALID), .BUS_ADDRESS(BUS_ADDRESS),
  .CALIB_FILTER_CUTOFF_SEL(CALIB_FILTER_CUTOFF_SEL), .CALIB_CUTOFF_CHZ(CALIB_CUTOFF_CHZ),
  .SIGNAL_FILTER_CUTOFF_SEL(SIGNAL_FILTER_CUTOFF_SEL), .SIGNAL_CUTOFF_CHZ(SIGNAL_CUTOFF_CHZ),
  .UPPER_LIMIT_OUTPUT(UPPER_LIMIT_OUTPUT), .LOWER_LIMIT_OUTPUT(LOWER_LIMIT_OUTPUT),
  .LIMITED_OUT(LIMITED_OUT), .COIL_SELF_TEST_BUSY(COIL_SELF_TEST_BUSY),
  .SLOW_SETTLE(SLOW_SETTLE));
